/* File: link_status_pkg.sv */
// package: register map, field layouts and encodings of the link status/error block
`default_nettype none
package link_status_pkg;
   localparam int unsigned REG_COUNT        = 16;
   localparam int unsigned ADDR_W           = 6;
   localparam logic [5:0]  STATUS_OFFSET    = 6'h00;
   localparam logic [5:0]  ERROR_LOG_OFFSET = 6'h04;
   localparam logic [31:0] STATUS_RESET     = 32'h0000_0000;
   localparam logic [31:0] ERROR_LOG_RESET  = 32'h0000_0000;

   // status field positions
   localparam int unsigned DETECT_LSB = 0;
   localparam int unsigned SPEED_LSB  = 4;
   localparam int unsigned POWER_LSB  = 8;

   // detect_state codes
   localparam logic [3:0] DET_NONE    = 4'h0;
   localparam logic [3:0] DET_PRESENT = 4'h1;
   localparam logic [3:0] DET_LINK_UP = 4'h3;
   localparam logic [3:0] DET_OFFLINE = 4'h4;
   // link_speed codes
   localparam logic [3:0] SPD_NONE = 4'h0;
   localparam logic [3:0] SPD_GEN1 = 4'h1;
   // power_state codes
   localparam logic [3:0] PWR_NONE    = 4'h0;
   localparam logic [3:0] PWR_ACTIVE  = 4'h1;
   localparam logic [3:0] PWR_PARTIAL = 4'h2;
   localparam logic [3:0] PWR_SLUMBER = 4'h6;

   // error summary bit positions
   localparam int unsigned ERR_RECOV_INTEGRITY = 0;
   localparam int unsigned ERR_RECOV_COMM      = 1;
   localparam int unsigned ERR_TRANSIENT       = 8;
   localparam int unsigned ERR_PERSISTENT      = 9;
   localparam int unsigned ERR_PROTOCOL        = 10;
   localparam int unsigned ERR_INTERNAL        = 11;
   // diagnostic bit positions
   localparam int unsigned DIAGNOSTIC_BITS_READY_CHANGE  = 16;
   localparam int unsigned DIAGNOSTIC_BITS_PHY_INTERNAL  = 17;
   localparam int unsigned DIAGNOSTIC_BITS_WAKE          = 18;
   localparam int unsigned DIAGNOSTIC_BITS_DECODE        = 19;
   localparam int unsigned DIAGNOSTIC_BITS_DISPARITY     = 20;
   localparam int unsigned DIAGNOSTIC_BITS_CRC           = 21;
   localparam int unsigned DIAGNOSTIC_BITS_HANDSHAKE     = 22;
   localparam int unsigned DIAGNOSTIC_BITS_LINK_SEQ      = 23;
   localparam int unsigned DIAGNOSTIC_BITS_TRANSPORT     = 24;
   localparam int unsigned DIAGNOSTIC_BITS_UNKNOWN_FRAME = 25;
   localparam logic [31:0] ERROR_LOG_MASK     = 32'h03FF_0F03;

   // live link state as reported by the physical layer
   typedef enum {
      LINK_NO_DEVICE,
      LINK_PRESENT,
      LINK_UP,
      LINK_OFFLINE
   } link_state_t;

   typedef struct packed {
      logic       device_present;
      logic       comm_up;
      logic       offline;
      logic       gen1_speed;
      logic       partial;
      logic       slumber;
   } phy_state_t;

   typedef struct packed {
      logic recov_integrity;
      logic transient;
      logic persistent;
      logic protocol;
      logic internal;
      logic phy_internal;
      logic wake;
      logic decode;
      logic disparity;
      logic crc;
      logic handshake;
      logic link_seq;
      logic transport;
      logic unknown_frame;
   } error_events_t;

   typedef struct packed {
      logic [5:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;
endpackage : link_status_pkg
`default_nettype wire

/* File: pin_sync.sv */
// module: three-stage synchroniser with agreement filter for WIDTH asynchronous levels, each bit filtered on its own
`default_nettype none
module pin_sync
   import link_status_pkg::*;
#(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage3_reg;

   initial begin
      if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
      end else begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   // a bit only moves once stages two and three agree
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync_out <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2_reg[i] == stage3_reg[i]) begin
               sync_out[i] <= stage3_reg[i];
            end
         end
      end
   end
endmodule // pin_sync
`default_nettype wire

/* File: link_status_regs.sv */
// module: interface status and sticky error log registers of the serial link adapter
//
// How it works
// - status register is read-only; writes ignored
// - status tracks live interface state continuously
// - detect codes: none, present, up, offline
// - speed codes: none or first generation
// - power codes: none, active, partial, slumber
// - reserved bits always read zero
// - power saving forces detect to no-link code
// - error log accumulates every error, sticky
// - write ones clears; reset clears all
// - persistent failure sets its bit
// - adapter internal fault sets its bit
// - recovered integrity error sets its bit
// - link lost then regained sets bit
// - protocol violation sets protocol bit
// - transient unrecovered error sets its bit
// - decode and disparity errors set bits
// - link CRC errors set CRC bit
// - unknown frame type sets its bit
// - ready change and phy fault set bits
// - negative handshake response sets its bit
// - link and transport transition errors
// - wake signal detected sets its bit
// - sixteen words: status, error log, reserved
//
// Added by the designer: the register addresses and the address-and-strobe port.
`default_nettype none
module link_status_regs
   import link_status_pkg::*;
#(
   parameter int unsigned DATA_W = 32
) (
   input  wire logic          clk,
   input  wire logic          arst_n,
   input  wire reg_req_t      reg_req,
   output var  logic [31:0]   rdata,
   input  wire phy_state_t    phy_state_async,
   input  wire logic          phy_ready_signal_async,
   input  wire error_events_t err_events,
   output var  logic          phy_not_ready_signal
);
   phy_state_t    phy_state;
   logic          phy_ready;
   logic          phy_ready_prev_reg;
   logic          link_was_lost_reg;
   link_state_t   link_state;
   logic [3:0]    detect_state;
   logic [3:0]    link_speed;
   logic [3:0]    power_state;
   logic [31:0]   status_word;
   logic [31:0]   error_log_reg;
   logic [31:0]   error_set;
   logic [31:0]   error_clear;
   logic [31:0]   error_log_next;
   logic          hit_status;
   logic          hit_error;

   initial begin
      if (DATA_W != 32) $error("link_status_regs: only a 32-bit data path is supported");
   end

   // physical-layer levels come from another domain
   pin_sync #(
      .WIDTH ($bits(phy_state_t) + 1)
   ) u_phy_sync (
      .clk      (clk),
      .arst_n   (arst_n),
      .async_in ({phy_state_async, phy_ready_signal_async}),
      .sync_out ({phy_state, phy_ready})
   );

   assign phy_not_ready_signal = ~phy_ready;

   // classify the live link condition; offline outranks everything
   always_comb begin
      if (phy_state.offline) begin
         link_state = LINK_OFFLINE;
      end else if (!phy_state.device_present) begin
         link_state = LINK_NO_DEVICE;
      end else if (phy_state.comm_up && !phy_state.partial && !phy_state.slumber) begin
         link_state = LINK_UP;
      end else begin
         // no communication exists while power saving
         link_state = LINK_PRESENT;
      end
   end

   always_comb begin
      case (link_state)
         LINK_NO_DEVICE: detect_state = DET_NONE;
         LINK_PRESENT:   detect_state = DET_PRESENT;
         LINK_UP:        detect_state = DET_LINK_UP;
         LINK_OFFLINE:   detect_state = DET_OFFLINE;
         default:        detect_state = DET_NONE;
      endcase
   end

   // speed and power only mean something once the link has been negotiated
   always_comb begin
      link_speed  = SPD_NONE;
      power_state = PWR_NONE;
      if (phy_state.device_present && !phy_state.offline && phy_state.comm_up) begin
         link_speed = phy_state.gen1_speed ? SPD_GEN1 : SPD_NONE;
         if (phy_state.slumber) begin
            power_state = PWR_SLUMBER;
         end else if (phy_state.partial) begin
            power_state = PWR_PARTIAL;
         end else begin
            power_state = PWR_ACTIVE;
         end
      end
   end

   // built fresh every cycle, so a read sees the present state
   always_comb begin
      status_word = STATUS_RESET;
      status_word[DETECT_LSB +: 4] = detect_state;
      status_word[SPEED_LSB +: 4]  = link_speed;
      status_word[POWER_LSB +: 4]  = power_state;
   end

   // ready edge detection on the filtered level only
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phy_ready_prev_reg <= 1'b0;
      end else begin
         phy_ready_prev_reg <= phy_ready;
      end
   end

   // remember a ready drop so its return counts as a recovered loss
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         link_was_lost_reg <= 1'b0;
      end else if (phy_ready_prev_reg && !phy_ready) begin
         link_was_lost_reg <= 1'b1;
      end else if (!phy_ready_prev_reg && phy_ready) begin
         link_was_lost_reg <= 1'b0;
      end
   end

   always_comb begin
      error_set = '0;
      error_set[ERR_RECOV_INTEGRITY] = err_events.recov_integrity;
      error_set[ERR_RECOV_COMM]      = link_was_lost_reg && !phy_ready_prev_reg
                                       && phy_ready;
      error_set[ERR_TRANSIENT]       = err_events.transient;
      error_set[ERR_PERSISTENT]      = err_events.persistent;
      error_set[ERR_PROTOCOL]        = err_events.protocol;
      error_set[ERR_INTERNAL]        = err_events.internal;
      error_set[DIAGNOSTIC_BITS_READY_CHANGE]   = phy_ready_prev_reg ^ phy_ready;
      error_set[DIAGNOSTIC_BITS_PHY_INTERNAL]   = err_events.phy_internal;
      error_set[DIAGNOSTIC_BITS_WAKE]           = err_events.wake;
      error_set[DIAGNOSTIC_BITS_DECODE]         = err_events.decode;
      error_set[DIAGNOSTIC_BITS_DISPARITY]      = err_events.disparity;
      error_set[DIAGNOSTIC_BITS_CRC]            = err_events.crc;
      error_set[DIAGNOSTIC_BITS_HANDSHAKE]      = err_events.handshake;
      error_set[DIAGNOSTIC_BITS_LINK_SEQ]       = err_events.link_seq;
      error_set[DIAGNOSTIC_BITS_TRANSPORT]      = err_events.transport;
      error_set[DIAGNOSTIC_BITS_UNKNOWN_FRAME]  = err_events.unknown_frame;
   end

   // word-aligned decode; upper index bits select reserved words
   assign hit_status = (reg_req.addr == STATUS_OFFSET);
   assign hit_error  = (reg_req.addr == ERROR_LOG_OFFSET);

   assign error_clear = (reg_req.wr && hit_error) ? reg_req.wdata : 32'h0000_0000;

   // set applied after clear, so a same-cycle event survives
   assign error_log_next = ((error_log_reg & ~error_clear) | error_set)
                           & ERROR_LOG_MASK;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         error_log_reg <= ERROR_LOG_RESET;
      end else begin
         error_log_reg <= error_log_next;
      end
   end

   // writes to the status word and reserved words fall on the floor
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 32'h0000_0000;
      end else if (reg_req.rd && hit_status) begin
         rdata <= status_word;
      end else if (reg_req.rd && hit_error) begin
         rdata <= error_log_reg;
      end else begin
         rdata <= 32'h0000_0000;
      end
   end
endmodule // link_status_regs
`default_nettype wire

/* File: link_status_monitor.sv */
// checker: port-level properties of the link status and error log registers
`default_nettype none
module link_status_monitor
   import link_status_pkg::*;
(
   input wire logic          clk,
   input wire logic          arst_n,
   input wire reg_req_t      reg_req,
   input wire logic [31:0]   rdata,
   input wire phy_state_t    phy_state_async,
   input wire logic          phy_ready_signal_async,
   input wire error_events_t err_events,
   input wire logic          phy_not_ready_signal
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire logic rd_st = reg_req.rd && reg_req.addr == STATUS_OFFSET;
   wire logic rd_log = reg_req.rd && reg_req.addr == ERROR_LOG_OFFSET;
   wire logic clr_all = reg_req.wr && reg_req.addr == ERROR_LOG_OFFSET && &reg_req.wdata;
   wire logic quiet = err_events == '0;
   sequence crc_then_read;
      err_events.crc ##1 rd_log;
   endsequence
   sequence fault_beats_clear;
      err_events.internal && clr_all ##1 rd_log;
   endsequence
   AST_IDLE_ZERO: assert property (!reg_req.rd |=> rdata == 32'h0)
      else $error("read data not zero outside a read");
   AST_STATUS_RSVD: assert property (rd_st |=> rdata[31:12] == 20'h0)
      else $error("status reserved bits set");
   AST_LOG_RSVD: assert property (rd_log |=> (rdata & ~ERROR_LOG_MASK) == 32'h0)
      else $error("error log reserved bits set");
   AST_SPARE_ZERO: assert property (reg_req.rd && reg_req.addr >= 6'h08 |=> rdata == 32'h0)
      else $error("spare word not zero");
   AST_CODES: assert property (rd_st |=> rdata[3:0] inside {4'h0, 4'h1, 4'h3, 4'h4}
      && rdata[7:4] inside {4'h0, 4'h1} && rdata[11:8] inside {4'h0, 4'h1, 4'h2, 4'h6})
      else $error("status field holds a reserved code");
   AST_SAVE_DETECT: assert property (rd_st ##1 rdata[11:8] inside {PWR_PARTIAL, PWR_SLUMBER}
      |-> rdata[3:0] inside {DET_NONE, DET_PRESENT})
      else $error("detect shows link while power saving");
   AST_CRC_STICKY: assert property (crc_then_read |=> rdata[DIAGNOSTIC_BITS_CRC])
      else $error("crc bit not set");
   AST_SET_WINS: assert property (fault_beats_clear |=> rdata[ERR_INTERNAL])
      else $error("event lost to clear");
   AST_CLEARED: assert property (clr_all && quiet ##1 rd_log && quiet
      |=> (rdata & 32'h03FE_0F01) == 32'h0)
      else $error("error bits survive clear");
   AST_NOT_READY: assert property ($stable(phy_ready_signal_async)[*8]
      |-> phy_not_ready_signal == !phy_ready_signal_async)
      else $error("not-ready level wrong");
endmodule // link_status_monitor
bind link_status_regs link_status_monitor mon_u (.clk(clk), .arst_n(arst_n),
   .reg_req(reg_req), .rdata(rdata), .phy_state_async(phy_state_async),
   .phy_ready_signal_async(phy_ready_signal_async), .err_events(err_events),
   .phy_not_ready_signal(phy_not_ready_signal));
`default_nettype wire

/* File: link_status_regs_bench.sv */
// bench: self-checking test of the link status and error log registers
`default_nettype none
module link_status_regs_bench import link_status_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic          clk;
   logic          arst_n;
   reg_req_t      req;
   logic [31:0]   rdata;
   phy_state_t    phy;
   phy_state_t    ps;
   logic          rdy;
   error_events_t ev;
   logic          nrdy;
   logic [31:0]   rnd;
   logic [31:0]   got;
   logic [31:0]   exp_log;
   int            n_errors;
   int            n_tests;
   // log position of each event bit, struct lsb first
   localparam int POS [14] = '{25, 24, 23, 22, 21, 20, 19, 18, 17, 11, 10, 9, 8, 0};
   link_status_regs dut_u (.clk(clk), .arst_n(arst_n), .reg_req(req), .rdata(rdata),
      .phy_state_async(phy), .phy_ready_signal_async(rdy), .err_events(ev),
      .phy_not_ready_signal(nrdy));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'h0} ^ (x[31] ? 32'h04C1_1DB7 : 32'h0);
   endfunction
   function automatic logic [31:0] ev_bits(input error_events_t e);
      logic [31:0] b;
      b = '0;
      for (int i = 0; i < 14; i++) b[POS[i]] = e[i];
      return b;
   endfunction
   function automatic logic [31:0] exp_status(input phy_state_t p);
      logic [3:0] d;
      logic [3:0] s;
      logic [3:0] w;
      d = p.offline ? DET_OFFLINE : !p.device_present ? DET_NONE
        : (p.comm_up && !p.partial && !p.slumber) ? DET_LINK_UP : DET_PRESENT;
      s = (!p.offline && p.comm_up && p.gen1_speed) ? SPD_GEN1 : SPD_NONE;
      w = (p.offline || !p.comm_up) ? PWR_NONE : p.partial ? PWR_PARTIAL
        : p.slumber ? PWR_SLUMBER : PWR_ACTIVE;
      return {20'h0, w, s, d};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   // no trailing idle: a read or another write may follow at once
   task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'h1;
      @(posedge clk);
      req.wr <= 1'h0;
   endtask
   task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
      req.addr <= a;
      req.rd <= 1'h1;
      @(posedge clk);
      req.rd <= 1'h0;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [31:0] want);
      rd_reg(a, got);
      chk(got, want);
   endtask
   task automatic pulse(input error_events_t e);
      ev <= e;
      @(posedge clk);
      ev <= '0;
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      final_report;
   end
   initial begin
      arst_n = 1'h0;
      req = '0;
      phy = '0;
      rdy = 1'h0;
      ev = '0;
      rnd = 32'h90CF_C625;
      exp_log = 32'h0;
      n_errors = 0;
      n_tests = 0;
      repeat (8) @(posedge clk);
      arst_n <= 1'h1;
      @(posedge clk);
      for (int a = 0; a < 16; a++) rd_chk(6'(4 * a), 32'h0);
      wr_reg(STATUS_OFFSET, 32'hFFFF_FFFF);
      rd_chk(STATUS_OFFSET, 32'h0);
      wr_reg(6'h08, 32'hFFFF_FFFF);
      rd_chk(6'h08, 32'h0);
      repeat (24) begin
         rnd = lfsr(rnd);
         ps = phy_state_t'(rnd[5:0]);
         // keep to combinations the physical layer can report
         ps.device_present = ps.device_present | ps.comm_up;
         ps.slumber = ps.slumber & ~ps.partial;
         phy <= ps;
         repeat (6) @(posedge clk);
         rd_chk(STATUS_OFFSET, exp_status(ps));
      end
      for (int i = 0; i < 14; i++) begin
         pulse(error_events_t'(14'h1 << i));
         exp_log |= ev_bits(error_events_t'(14'h1 << i));
         rd_chk(ERROR_LOG_OFFSET, exp_log);
      end
      repeat (20) begin
         rnd = lfsr(rnd);
         pulse(error_events_t'(rnd[13:0] & rnd[29:16]));
         exp_log |= ev_bits(error_events_t'(rnd[13:0] & rnd[29:16]));
         rnd = lfsr(rnd);
         wr_reg(ERROR_LOG_OFFSET, rnd);
         exp_log &= ~rnd;
         rd_chk(ERROR_LOG_OFFSET, exp_log);
      end
      wr_reg(ERROR_LOG_OFFSET, 32'hFFFF_FFFF);
      rd_chk(ERROR_LOG_OFFSET, 32'h0);
      ev.internal <= 1'h1;
      wr_reg(ERROR_LOG_OFFSET, 32'hFFFF_FFFF);
      ev <= '0;
      rd_chk(ERROR_LOG_OFFSET, 32'h0000_0800);
      rdy <= 1'h1;
      repeat (8) @(posedge clk);
      chk({31'h0, nrdy}, 32'h0);
      rd_reg(ERROR_LOG_OFFSET, got);
      chk(got & 32'h0001_0000, 32'h0001_0000);
      wr_reg(ERROR_LOG_OFFSET, 32'hFFFF_FFFF);
      rdy <= 1'h0;
      repeat (8) @(posedge clk);
      chk({31'h0, nrdy}, 32'h1);
      rdy <= 1'h1;
      repeat (8) @(posedge clk);
      rd_chk(ERROR_LOG_OFFSET, 32'h0001_0002);
      rdy <= 1'h0;
      pulse(error_events_t'(14'h3FFF));
      // log must be full before reset, or the clear below proves nothing
      rd_chk(ERROR_LOG_OFFSET, ERROR_LOG_MASK);
      arst_n <= 1'h0;
      repeat (2) @(posedge clk);
      arst_n <= 1'h1;
      @(posedge clk);
      rd_chk(ERROR_LOG_OFFSET, 32'h0);
      final_report;
   end
endmodule // link_status_regs_bench
`default_nettype wire
